// ---- rtl/otfr_core.sv ----
`timescale 1ns/100ps
module otfr_core #(
  parameter int CYCLES_PER_MS = otfr_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // Fault and supply sense
  input wire logic OT_FAULT_IN,
  input wire logic BIAS_LOSS_IN,
  // Register access
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic CFG_WR_IN,
  input wire logic [7:0] CFG_WDATA_IN,
  output logic [7:0] CFG_RDATA_OUT,
  // Power stage control and status
  output logic OUTPUT_EN_OUT,
  output logic FAULT_LATCHED_OUT,
  output logic FAULT_ACTIVE_OUT,
  output logic [2:0] RETRY_LEFT_OUT
);

  otfr_pkg::otfr_regs_t r_ff;
  otfr_pkg::otfr_regs_t nxt_r;
  logic ms_tick;
  logic tick_clr;

  // ==========================================================================
  // Millisecond time base
  otfr_ms_tick #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_tick (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .clr_in(tick_clr),
    .tick_out(ms_tick)
  );

  // ==========================================================================
  // Reaction helpers
  // Output off, then either wait for a restart or latch off
  function automatic otfr_pkg::otfr_regs_t shut_down(
    input otfr_pkg::otfr_regs_t s,
    input logic [2:0] left
  );
    otfr_pkg::otfr_regs_t t;
    t = s;
    t.out_en = 1'b0;
    if (left == otfr_pkg::RETRY_NONE) begin
      t.st = otfr_pkg::ST_LATCH;
      t.latched = 1'b1;
    end else begin
      t.st = otfr_pkg::ST_OFF_WAIT;
      t.ms_cnt = otfr_pkg::delay2_ms(s.cfg.dly);
    end
    t.retry_left = left;
    return t;
  endfunction

  // Start the programmed reaction to a present fault
  function automatic otfr_pkg::otfr_regs_t react(
    input otfr_pkg::otfr_regs_t s,
    input logic [2:0] left
  );
    otfr_pkg::otfr_regs_t t;
    t = s;
    case (s.cfg.resp)
      otfr_pkg::RESP_IGNORE: begin
        t.st = otfr_pkg::ST_RUN;
        t.out_en = 1'b1;
      end
      otfr_pkg::RESP_RIDE: begin
        t.st = otfr_pkg::ST_DELAY1;
        t.out_en = 1'b1;
        t.ms_cnt = otfr_pkg::delay1_ms(s.cfg.dly);
        t.retry_left = left;
      end
      otfr_pkg::RESP_SHUT: begin
        t = shut_down(s, left);
      end
      default: begin
        t.st = otfr_pkg::ST_HOLD;
        t.out_en = 1'b0;
      end
    endcase
    return t;
  endfunction

  // Is the loaded delay at its last millisecond
  function automatic logic last_ms(input logic [otfr_pkg::MS_W-1:0] cnt);
    return cnt <= otfr_pkg::MS_ONE;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_r = r_ff;
    tick_clr = 1'b0;
    // Two-stage input synchronisers
    nxt_r.ot_meta = OT_FAULT_IN;
    nxt_r.ot_sync = r_ff.ot_meta;
    nxt_r.bias_meta = BIAS_LOSS_IN;
    nxt_r.bias_sync = r_ff.bias_meta;
    // Register read-back of the settled configuration
    if (CFG_ADDR_IN == otfr_pkg::CFG_OFFSET) begin
      nxt_r.rdata = r_ff.cfg;
    end else begin
      nxt_r.rdata = otfr_pkg::RDATA_NONE;
    end
    // Fault sequencer
    case (r_ff.st)
      otfr_pkg::ST_RUN: begin
        nxt_r.out_en = 1'b1;
        nxt_r.retry_left = r_ff.cfg.retries;
        if (r_ff.ot_sync) begin
          nxt_r = react(nxt_r, r_ff.cfg.retries);
        end
      end
      otfr_pkg::ST_DELAY1: begin
        nxt_r.out_en = 1'b1;
        if (!r_ff.ot_sync) begin
          nxt_r.st = otfr_pkg::ST_RUN;
        end else if (ms_tick) begin
          if (last_ms(r_ff.ms_cnt)) begin
            nxt_r = shut_down(nxt_r, r_ff.retry_left);
          end else begin
            nxt_r.ms_cnt = r_ff.ms_cnt - otfr_pkg::MS_ONE;
          end
        end
      end
      otfr_pkg::ST_OFF_WAIT: begin
        nxt_r.out_en = 1'b0;
        if (ms_tick) begin
          if (last_ms(r_ff.ms_cnt)) begin
            nxt_r.st = otfr_pkg::ST_RETRY;
            nxt_r.out_en = 1'b1;
            nxt_r.ms_cnt = otfr_pkg::MS_ONE;
            if (r_ff.retry_left != otfr_pkg::RETRY_INF) begin
              nxt_r.retry_left = r_ff.retry_left - otfr_pkg::RETRY_ONE;
            end
          end else begin
            nxt_r.ms_cnt = r_ff.ms_cnt - otfr_pkg::MS_ONE;
          end
        end
      end
      otfr_pkg::ST_RETRY: begin
        nxt_r.out_en = 1'b1;
        if (ms_tick) begin
          if (!r_ff.ot_sync) begin
            nxt_r.st = otfr_pkg::ST_RUN;
          end else begin
            nxt_r = react(nxt_r, r_ff.retry_left);
          end
        end
      end
      otfr_pkg::ST_HOLD: begin
        nxt_r.out_en = 1'b0;
        if (!r_ff.ot_sync) begin
          nxt_r.st = otfr_pkg::ST_RUN;
          nxt_r.out_en = 1'b1;
        end
      end
      otfr_pkg::ST_LATCH: begin
        nxt_r.out_en = 1'b0;
        nxt_r.latched = 1'b1;
      end
      default: begin
        nxt_r.st = otfr_pkg::ST_RUN;
      end
    endcase
    // Register write lands after the sequencer, so a reaction started in
    // this cycle still works from the configuration it began the cycle with
    if (CFG_WR_IN && (CFG_ADDR_IN == otfr_pkg::CFG_OFFSET)) begin
      nxt_r.cfg = otfr_pkg::otfr_cfg_t'(CFG_WDATA_IN);
    end
    // Loss of bias power clears the sequencer and latch like a power cycle and reloads the retry count from the kept configuration
    if (r_ff.bias_sync) begin
      nxt_r.st = otfr_pkg::ST_RUN;
      nxt_r.latched = 1'b0;
      nxt_r.out_en = 1'b1;
      nxt_r.retry_left = r_ff.cfg.retries;
    end
    // Restart the time base whenever a new delay starts
    if ((nxt_r.st != r_ff.st) && (nxt_r.st != otfr_pkg::ST_RUN)) begin
      tick_clr = 1'b1;
    end
    nxt_r.active = (nxt_r.st != otfr_pkg::ST_RUN);
  end

  // State register
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      r_ff <= '0;
      r_ff.st <= otfr_pkg::ST_RUN;
      r_ff.cfg <= otfr_pkg::otfr_cfg_t'(otfr_pkg::CFG_RESET);
      r_ff.out_en <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================================
  // Outputs
  assign CFG_RDATA_OUT = r_ff.rdata;
  assign OUTPUT_EN_OUT = r_ff.out_en;
  assign FAULT_LATCHED_OUT = r_ff.latched;
  assign FAULT_ACTIVE_OUT = r_ff.active;
  assign RETRY_LEFT_OUT = r_ff.retry_left;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN || r_ff.bias_sync);

  sequence s_fault_in_run(logic [1:0] code);
    (r_ff.st == otfr_pkg::ST_RUN) && r_ff.ot_sync && (r_ff.cfg.resp == code);
  endsequence

  sequence s_enter(otfr_pkg::otfr_state_t s);
    (r_ff.st == s) && ($past(r_ff.st) != s);
  endsequence

  AST_IGNORE_KEEPS_ON: assert property (
    s_fault_in_run(otfr_pkg::RESP_IGNORE) |=> OUTPUT_EN_OUT && !FAULT_ACTIVE_OUT)
    else $error("fault ignored yet output or state changed");

  AST_RIDE_EXPIRY_OFF: assert property (
    (r_ff.st == otfr_pkg::ST_DELAY1) && r_ff.ot_sync && ms_tick && last_ms(r_ff.ms_cnt)
    |=> !OUTPUT_EN_OUT && (r_ff.st inside {otfr_pkg::ST_OFF_WAIT, otfr_pkg::ST_LATCH}))
    else $error("delay one expiry did not disable output");

  AST_SHUT_IMMEDIATE: assert property (
    s_fault_in_run(otfr_pkg::RESP_SHUT) |=> !OUTPUT_EN_OUT)
    else $error("shutdown code did not disable output at once");

  AST_HOLD_OFF: assert property (
    (r_ff.st == otfr_pkg::ST_HOLD) && r_ff.ot_sync |=> !OUTPUT_EN_OUT
    && (r_ff.st == otfr_pkg::ST_HOLD) && (RETRY_LEFT_OUT == $past(RETRY_LEFT_OUT)))
    else $error("hold mode released or retried while fault present");

  AST_HOLD_RELEASE: assert property (
    (r_ff.st == otfr_pkg::ST_HOLD) && !r_ff.ot_sync |=> OUTPUT_EN_OUT)
    else $error("hold mode did not re-enable output after fault cleared");

  AST_INF_RETRY: assert property (
    s_enter(otfr_pkg::ST_RETRY) ##0 ($past(r_ff.retry_left) == otfr_pkg::RETRY_INF)
    |-> RETRY_LEFT_OUT == otfr_pkg::RETRY_INF)
    else $error("unlimited retry count was decremented");

  AST_LATCH_HOLDS: assert property (
    FAULT_LATCHED_OUT |=> (FAULT_LATCHED_OUT && !OUTPUT_EN_OUT) [*3])
    else $error("latched fault released output");

  AST_LATCH_ONLY_FROM_EXHAUST: assert property (
    $rose(FAULT_LATCHED_OUT) |-> ($past(r_ff.retry_left) == otfr_pkg::RETRY_NONE)
    || ($past(r_ff.st) == otfr_pkg::ST_RUN))
    else $error("latch set with retries remaining");

  AST_DLY2_LOAD: assert property (
    s_enter(otfr_pkg::ST_OFF_WAIT)
    |-> r_ff.ms_cnt == otfr_pkg::delay2_ms($past(r_ff.cfg.dly)))
    else $error("restart spacing loaded with wrong delay");

  AST_DLY1_OUTPUT_ON: assert property (
    (r_ff.st == otfr_pkg::ST_DELAY1) |-> OUTPUT_EN_OUT)
    else $error("output disabled during delay one");

  AST_DLY1_LOAD: assert property (
    s_enter(otfr_pkg::ST_DELAY1) ##0 ($past(r_ff.st) == otfr_pkg::ST_RUN)
    |-> r_ff.ms_cnt == otfr_pkg::delay1_ms($past(r_ff.cfg.dly)))
    else $error("delay one loaded with wrong value");

  AST_RETRY_RELOAD: assert property (
    (r_ff.st == otfr_pkg::ST_RUN) ##1 (r_ff.st == otfr_pkg::ST_RUN)
    |-> RETRY_LEFT_OUT == $past(r_ff.cfg.retries))
    else $error("retry counter not reloaded while running");

  AST_RETRY_DEC: assert property (
    s_enter(otfr_pkg::ST_RETRY) ##0 ($past(r_ff.retry_left) != otfr_pkg::RETRY_INF)
    |-> RETRY_LEFT_OUT == ($past(r_ff.retry_left) - otfr_pkg::RETRY_ONE))
    else $error("limited retry count not decremented at restart");

  // Bias loss is the clearing event itself, so only reset disables this one
  AST_LATCH_CLEAR_CAUSE: assert property (
    disable iff (RST_IN)
    $fell(FAULT_LATCHED_OUT) |-> $past(r_ff.bias_sync))
    else $error("latched fault cleared without reset or bias loss");

  AST_OFF_WAIT_OFF: assert property (
    (r_ff.st == otfr_pkg::ST_OFF_WAIT) |-> !OUTPUT_EN_OUT)
    else $error("output enabled between restart attempts");

  AST_RESTART_ON: assert property (
    (r_ff.st == otfr_pkg::ST_RETRY) |-> OUTPUT_EN_OUT)
    else $error("restart attempt left output disabled");

  AST_HOLD_NO_LATCH: assert property (
    (r_ff.st == otfr_pkg::ST_HOLD) |-> !FAULT_LATCHED_OUT)
    else $error("hold mode latched the output off");

  AST_LATCH_ACTIVE: assert property (
    FAULT_LATCHED_OUT |-> FAULT_ACTIVE_OUT)
    else $error("latched fault shown with sequencer idle");

endmodule // otfr_core

// ---- rtl/otfr_ms_tick.sv ----
`timescale 1ns/100ps
module otfr_ms_tick #(
  parameter int CYCLES_PER_MS = otfr_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic clr_in,
  // Tick
  output logic tick_out
);
  localparam int CW = $clog2(CYCLES_PER_MS);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } otfr_tick_t;

  otfr_tick_t r_ff;
  otfr_tick_t nxt_r;

  // ==========================================================================
  // Millisecond divider, restarted when a delay is loaded
  always_comb begin
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    if (clr_in) begin
      nxt_r.cnt = '0;
    end else if (r_ff.cnt == CW'(CYCLES_PER_MS - 1)) begin
      nxt_r.cnt = '0;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign tick_out = r_ff.tick;
endmodule // otfr_ms_tick

// ---- rtl/otfr_pkg.sv ----
// Operation
// - Bits 7:6 pick the reaction; code 00 ignores the fault.
// - Code 01 keeps running for delay one, then retries if fault persists.
// - Code 10 disables output at once, then performs the programmed retries.
// - Code 11 holds output off while the fault stays, with no retries.
// - Code 11 re-enables the output once the fault has gone.
// - Bits 5:3 give 0 to 6 retries; 111 retries without limit.
// - Retries used up with fault present latches the output off.
// - Latch clears only on reset, power cycle or bias power loss.
// - Restart attempts are spaced by delay two from bits 2:0.
// - With code 01, after detection, wait delay one from bits 2:0 before disabling.
// - Delay one doubles from 10 to 1280 ms; delay two 252 to 2604 ms.
package otfr_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_FREQ_HZ / MS_PER_S;
  localparam int MS_W = 12;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CFG_OFFSET = 8'h50;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RIDE = 2'h1;
  localparam logic [1:0] RESP_SHUT = 2'h2;
  localparam logic [1:0] RESP_HOLDOFF = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_ONE = 3'h1;
  localparam logic [2:0] RETRY_INF = 3'h7;

  // ==========================================================================
  // Delay figures in milliseconds
  localparam logic [MS_W-1:0] MS_ONE = 12'h001;
  localparam logic [MS_W-1:0] DLY1_BASE_MS = 12'h00A; // 10 ms
  localparam logic [MS_W-1:0] DLY2_MS_0 = 12'h0FC; // 252 ms
  localparam logic [MS_W-1:0] DLY2_MS_1 = 12'h22E; // 558 ms
  localparam logic [MS_W-1:0] DLY2_MS_2 = 12'h39C; // 924 ms
  localparam logic [MS_W-1:0] DLY2_MS_3 = 12'h4EC; // 1260 ms
  localparam logic [MS_W-1:0] DLY2_MS_4 = 12'h63C; // 1596 ms
  localparam logic [MS_W-1:0] DLY2_MS_5 = 12'h78C; // 1932 ms
  localparam logic [MS_W-1:0] DLY2_MS_6 = 12'h8DC; // 2268 ms
  localparam logic [MS_W-1:0] DLY2_MS_7 = 12'hA2C; // 2604 ms

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] dly;
  } otfr_cfg_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY1,
    ST_OFF_WAIT,
    ST_RETRY,
    ST_HOLD,
    ST_LATCH
  } otfr_state_t;

  typedef struct packed {
    otfr_state_t st;
    logic [MS_W-1:0] ms_cnt;
    logic [2:0] retry_left;
    otfr_cfg_t cfg;
    logic [7:0] rdata;
    logic out_en;
    logic latched;
    logic active;
    logic ot_meta;
    logic ot_sync;
    logic bias_meta;
    logic bias_sync;
  } otfr_regs_t;

  // ==========================================================================
  // Delay decoders
  function automatic logic [MS_W-1:0] delay1_ms(input logic [2:0] code);
    delay1_ms = DLY1_BASE_MS << code;
  endfunction

  function automatic logic [MS_W-1:0] delay2_ms(input logic [2:0] code);
    case (code)
      3'h0: delay2_ms = DLY2_MS_0;
      3'h1: delay2_ms = DLY2_MS_1;
      3'h2: delay2_ms = DLY2_MS_2;
      3'h3: delay2_ms = DLY2_MS_3;
      3'h4: delay2_ms = DLY2_MS_4;
      3'h5: delay2_ms = DLY2_MS_5;
      3'h6: delay2_ms = DLY2_MS_6;
      default: delay2_ms = DLY2_MS_7;
    endcase
  endfunction

endpackage

// ---- verif/otfr_far_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Far side: temperature fault detector and power stage
module otfr_far_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Demand from the bench and enable from the block
  input wire logic heat_in,
  input wire logic en_in,
  // Fault line and count of power stage turn-offs
  output logic fault_out,
  output int off_cnt_out
);
  logic en_last;

  // Detector raises its fault flag one clock after the demand
  always_ff @(posedge clk_in) begin
    fault_out <= heat_in;
  end

  // Power stage counts each turn-off of its enable
  always_ff @(posedge clk_in) begin
    en_last <= en_in;
    if (rst_in) begin
      off_cnt_out <= 0;
    end else if (en_last && !en_in) begin
      off_cnt_out <= off_cnt_out + 1;
    end
  end
endmodule // otfr_far_model

// ---- verif/tb.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Self-checking bench of the overtemperature fault response
module tb;
  localparam int CPM = 10;
  logic clk_sys, rst, fault, bias_loss, wr, heat, en, latched, active;
  logic [7:0] addr, wdata, rdata, v, d;
  logic [2:0] left, code;
  logic [31:0] lfsr;
  int off_cnt, error_cnt, checks, n;

  // Clock of 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  otfr_core #(.CYCLES_PER_MS(CPM)) DUT (.CLK_SYS_IN(clk_sys), .RST_IN(rst),
    .OT_FAULT_IN(fault), .BIAS_LOSS_IN(bias_loss), .CFG_ADDR_IN(addr), .CFG_WR_IN(wr),
    .CFG_WDATA_IN(wdata), .CFG_RDATA_OUT(rdata), .OUTPUT_EN_OUT(en),
    .FAULT_LATCHED_OUT(latched), .FAULT_ACTIVE_OUT(active), .RETRY_LEFT_OUT(left));

  otfr_far_model far (.clk_in(clk_sys), .rst_in(rst), .heat_in(heat), .en_in(en),
    .fault_out(fault), .off_cnt_out(off_cnt));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int dly1_cyc(input logic [2:0] c);
    dly1_cyc = 10 * CPM * (1 << c);
  endfunction

  // Restart spacing in clocks for each delay code
  function automatic int dly2_cyc(input logic [2:0] c);
    case (c)
      3'h0: dly2_cyc = 252 * CPM;
      3'h1: dly2_cyc = 558 * CPM;
      3'h2: dly2_cyc = 924 * CPM;
      3'h3: dly2_cyc = 1260 * CPM;
      3'h4: dly2_cyc = 1596 * CPM;
      3'h5: dly2_cyc = 1932 * CPM;
      3'h6: dly2_cyc = 2268 * CPM;
      default: dly2_cyc = 2604 * CPM;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
    addr = a;
    wdata = dat;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] dat);
    addr = a;
    tick(2);
    dat = rdata;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    heat = 1'b0;
    bias_loss = 1'b0;
    tick(20);
    rst = 1'b0;
  endtask

  // Bounded wait for the enable level; cycles taken go to n
  task automatic wait_en(input logic lvl, input int bound);
    n = 0;
    while (en !== lvl && n < bound) begin
      tick(1);
      n++;
    end
    if (en !== lvl) begin
      error_cnt++;
      $display("wait for enable timed out at %0t", $time);
      test_done();
    end
  endtask

  function automatic logic [7:0] in_rng(input int x, input int lo, input int hi);
    in_rng = {7'h00, (x >= lo && x <= hi)};
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    lfsr = 32'h9b4f;
    error_cnt = 0;
    checks = 0;
    do_reset();
    cmp({2'h0, en, latched, active, left}, 8'h20);
    reg_rd(8'h50, d);
    cmp(d, otfr_pkg::CFG_RESET);
    // Random config values, reads and writes elsewhere
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0];
      reg_wr(8'h50, v);
      reg_rd(8'h50, d);
      cmp(d, v);
      reg_wr((lfsr[15:8] == 8'h50) ? 8'h51 : lfsr[15:8], ~v);
      reg_rd(8'h50, d);
      cmp(d, v);
      reg_rd(8'h51, d);
      cmp(d, 8'h00);
    end
    // Code 00 ignores the fault
    do_reset();
    reg_wr(8'h50, {2'h0, lfsr[13:8]});
    heat = 1'b1;
    tick(300);
    cmp({5'h00, en, latched, active}, 8'h04);
    // Code 11 holds off while the fault stays, then re-enables
    do_reset();
    reg_wr(8'h50, {2'h3, lfsr[18:16], 3'h0});
    heat = 1'b1;
    wait_en(1'b0, 6);
    tick(3000);
    cmp({6'h00, en, latched}, 8'h00);
    cmp(off_cnt[7:0], 8'h01);
    heat = 1'b0;
    wait_en(1'b1, 6);
    cmp({7'h00, latched}, 8'h00);
    // Code 10, one retry at a random spacing, then latch
    do_reset();
    lfsr = lfsr_next(lfsr);
    code = lfsr[2:0];
    reg_wr(8'h50, {2'h2, 3'h1, code});
    heat = 1'b1;
    wait_en(1'b0, 6);
    cmp({2'h0, en, latched, active, left}, 8'h09);
    wait_en(1'b1, dly2_cyc(code) + 100);
    cmp(in_rng(n, dly2_cyc(code) - 12, dly2_cyc(code) + 12), 8'h01);
    cmp({2'h0, en, latched, active, left}, 8'h28);
    wait_en(1'b0, CPM + 8);
    tick(2);
    cmp({5'h00, en, latched, active}, 8'h03);
    cmp(off_cnt[7:0], 8'h02);
    heat = 1'b0;
    tick(3000);
    cmp({6'h00, en, latched}, 8'h01);
    bias_loss = 1'b1;
    tick(6);
    bias_loss = 1'b0;
    tick(6);
    cmp({6'h00, en, latched}, 8'h02);
    // Unlimited retries keep the count at its top code
    do_reset();
    reg_wr(8'h50, {2'h2, 3'h7, 3'h0});
    heat = 1'b1;
    wait_en(1'b0, 6);
    cmp({5'h00, left}, 8'h07);
    wait_en(1'b1, 2600);
    tick(1);
    cmp({5'h00, left}, 8'h07);
    wait_en(1'b0, CPM + 8);
    wait_en(1'b1, 2600);
    cmp({4'h0, latched, left}, 8'h07);
    cmp(off_cnt[7:0], 8'h02);
    // Code 01 rides through delay one, then latches with no retries
    do_reset();
    lfsr = lfsr_next(lfsr);
    code = lfsr[2:0] % 3'h3;
    reg_wr(8'h50, {2'h1, 3'h0, code});
    heat = 1'b1;
    tick(dly1_cyc(code) - CPM);
    cmp({7'h00, en}, 8'h01);
    wait_en(1'b0, 2 * CPM + 8);
    cmp(in_rng(n, CPM, 2 * CPM), 8'h01);
    tick(2);
    cmp({7'h00, latched}, 8'h01);
    do_reset();
    cmp({6'h00, en, latched}, 8'h02);
    test_done();
  end
endmodule // tb
